// ### src/acs_conv_if.sv
`timescale 1ns/10ps

interface acs_conv_if;
  logic                start;
  logic                abort;
  acs_pkg::acs_time_e  time_code;
  logic                busy;
  logic                done;

  modport seq   (output start, output abort, output time_code, input busy, input done);
  modport timer (input start, input abort, input time_code, output busy, output done);
endinterface : acs_conv_if

// ### src/acs_irq_unit.sv
`timescale 1ns/10ps

`include "acs_params.svh"

module acs_irq_unit (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // Events and software access
  input  wire logic [`ACS_NUM_EV-1:0] event_set,
  input  wire logic                   status_rd,
  input  wire logic                   mask_wr,
  input  wire logic [`ACS_NUM_EV-1:0] mask_wdata,
  // State
  output logic      [`ACS_NUM_EV-1:0] status,
  output logic      [`ACS_NUM_EV-1:0] mask,
  output logic                        irq
);

  acs_pkg::acs_irq_s s;
  acs_pkg::acs_irq_s next_s;

  always_comb begin
    next_s = s;
    // An event in the clearing read's cycle survives the read
    for (int i = 0; i < `ACS_NUM_EV; i++) begin
      next_s.status[i] = (s.status[i] && !status_rd) || event_set[i];
    end
    if (mask_wr) begin
      next_s.mask = mask_wdata;
    end
    next_s.irq = |(next_s.status & next_s.mask);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{status: '0, mask: `ACS_MASK_RST, irq: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign status = s.status;
  assign mask   = s.mask;
  assign irq    = s.irq;

  AST_SET_WINS: assert property (@(posedge clock) disable iff (!arst_n)
    (status_rd && event_set[`ACS_EV_DONE]) |=> status[`ACS_EV_DONE])
    else $error("event lost in clearing read");

endmodule : acs_irq_unit

// ### src/acs_params.svh
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ----------------------------------------------------------------
// Register indices on the plain register port
// ----------------------------------------------------------------
`define ACS_ADDR_CTRL1      3'h0
`define ACS_ADDR_CTRL2      3'h1
`define ACS_ADDR_RESULT     3'h2
`define ACS_ADDR_STATUS     3'h3
`define ACS_ADDR_IRQ_STAT   3'h4
`define ACS_ADDR_IRQ_MASK   3'h5

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACS_CR1_START       7
`define ACS_CR1_AIN_DIS     4
`define ACS_CR1_CHAN_HI     3
`define ACS_CR1_CHAN_LO     0
`define ACS_CR2_REF_ON      5
`define ACS_CR2_TIME_HI     3
`define ACS_CR2_TIME_LO     1
`define ACS_ST_END          5
`define ACS_ST_BUSY         4
`define ACS_EV_DONE         0
`define ACS_EV_ABORT        1
`define ACS_NUM_EV          2

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACS_CR1_RST         8'h10
`define ACS_CR2_RST         8'h00
`define ACS_RESULT_RST      8'h00
`define ACS_MASK_RST        2'h0

// ----------------------------------------------------------------
// Conversion times in system clock periods
// ----------------------------------------------------------------
`define ACS_CNT_W           11
`define ACS_CYC_39          11'h027
`define ACS_CYC_78          11'h04e
`define ACS_CYC_156         11'h09c
`define ACS_CYC_312         11'h138
`define ACS_CYC_624         11'h270
`define ACS_CYC_1248        11'h4e0

`endif

// ### src/acs_pkg.sv
`include "acs_params.svh"

package acs_pkg;

  typedef enum logic [2:0] {
    ACS_T39   = 3'b000,
    ACS_RSV1  = 3'b001,
    ACS_T78   = 3'b010,
    ACS_T156  = 3'b011,
    ACS_T312  = 3'b100,
    ACS_T624  = 3'b101,
    ACS_T1248 = 3'b110,
    ACS_RSV7  = 3'b111
  } acs_time_e;

  typedef enum logic {
    ACS_IDLE = 1'b0,
    ACS_CONV = 1'b1
  } acs_conv_state_e;

  typedef struct packed {
    acs_conv_state_e          state;
    logic [`ACS_CNT_W-1:0]    remain;
    logic                     done;
  } acs_timer_s;

  typedef struct packed {
    logic [`ACS_NUM_EV-1:0]   status;
    logic [`ACS_NUM_EV-1:0]   mask;
    logic                     irq;
  } acs_irq_s;

  typedef struct packed {
    logic [7:0]               ctrl1;
    logic [7:0]               ctrl2;
    logic [7:0]               result;
    logic                     end_flag;
    logic                     done_irq;
    logic [7:0]               rdata;
  } acs_top_s;

endpackage : acs_pkg

// ### src/acs_timer.sv
`timescale 1ns/10ps

`include "acs_params.svh"

module acs_timer (
  // Clock and reset
  input wire logic  clock,
  input wire logic  arst_n,
  // Sequencer side
  acs_conv_if.timer conv
);

  acs_pkg::acs_timer_s s;
  acs_pkg::acs_timer_s next_s;

  // Reserved codes run the longest time so a bad setting never shortens sampling
  // code to cycle count
  function automatic logic [`ACS_CNT_W-1:0] conv_cycles(input acs_pkg::acs_time_e code);
    unique case (code)
      acs_pkg::ACS_T39:   conv_cycles = `ACS_CYC_39;
      acs_pkg::ACS_T78:   conv_cycles = `ACS_CYC_78;
      acs_pkg::ACS_T156:  conv_cycles = `ACS_CYC_156;
      acs_pkg::ACS_T312:  conv_cycles = `ACS_CYC_312;
      acs_pkg::ACS_T624:  conv_cycles = `ACS_CYC_624;
      acs_pkg::ACS_T1248: conv_cycles = `ACS_CYC_1248;
      acs_pkg::ACS_RSV1:  conv_cycles = `ACS_CYC_1248;
      acs_pkg::ACS_RSV7:  conv_cycles = `ACS_CYC_1248;
    endcase
  endfunction : conv_cycles

  always_comb begin
    next_s      = s;
    next_s.done = 1'b0;
    unique case (s.state)
      acs_pkg::ACS_IDLE: begin
        if (conv.start && !conv.abort) begin
          next_s.state  = acs_pkg::ACS_CONV;
          next_s.remain = conv_cycles(conv.time_code) - `ACS_CNT_W'(1);
        end
      end
      acs_pkg::ACS_CONV: begin
        if (conv.abort) begin
          next_s.state = acs_pkg::ACS_IDLE;
        end else if (s.remain == '0) begin
          next_s.state = acs_pkg::ACS_IDLE;
          next_s.done  = 1'b1;
        end else begin
          next_s.remain = s.remain - `ACS_CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{state: acs_pkg::ACS_IDLE, remain: '0, done: 1'b0};
    end else begin
      s <= next_s;
    end
  end

  assign conv.busy = (s.state == acs_pkg::ACS_CONV);
  assign conv.done = s.done;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  AST_TIME_39: assert property (@(posedge clock) disable iff (!arst_n || conv.abort)
    (!conv.busy && conv.start && conv.time_code == acs_pkg::ACS_T39) |-> ##40 conv.done)
    else $error("39-cycle conversion did not finish on time");
  AST_TIME_78: assert property (@(posedge clock) disable iff (!arst_n || conv.abort)
    (!conv.busy && conv.start && conv.time_code == acs_pkg::ACS_T78)
      |-> ##1 (!conv.done) [*8] ##71 conv.done)
    else $error("78-cycle conversion did not finish on time");
  AST_NO_EARLY_DONE: assert property (@(posedge clock) disable iff (!arst_n)
    conv.done |-> $past(conv.busy) && $past(s.remain) == '0)
    else $error("conversion finished before its time ran out");

endmodule : acs_timer

// ### src/acs_top.sv
// The placing of the registers and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/10ps
`include "acs_params.svh"

// Contract
// - Start bit launches conversion of selected channel
// - Completion stores result, sets flag, requests interrupt
// - Start bit clears itself after launch
// - Completion only after selected conversion time
// - Reading result clears end flag
// - Restart clears end flag, keeps old result
// - Stop/slow aborts and resets both controls
// - Stop/slow discards held result
// - No automatic resume after low power
// - Stop/slow disconnects analog reference
// - Result is full unsigned 8-bit code
// - Busy flag tracks running conversion
// - Time codes map to fixed cycle counts
// - Low power holds controls, ignores writes

module acs_top (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Register port
  input  wire logic [2:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  // Power modes
  input  wire logic       stop_slow_mode,
  input  wire logic       sleep_mode,
  // Analog front end
  input  wire logic [7:0] conv_code,
  output logic      [3:0] channel_select,
  output logic            analog_input_disable,
  output logic            ref_current_on,
  output logic            sample_active,
  // Interrupts
  output logic            conv_done_irq,
  output logic            irq
);

  // ----------------------------------------------------------------
  // State and sub-blocks
  // ----------------------------------------------------------------
  acs_pkg::acs_top_s              s;
  acs_pkg::acs_top_s              next_s;
  acs_conv_if                     conv ();
  logic [`ACS_NUM_EV-1:0]         ev_set;
  logic [`ACS_NUM_EV-1:0]         ev_status;
  logic [`ACS_NUM_EV-1:0]         ev_mask;
  logic                           low_power;
  logic                           start_take;
  logic                           wr_ctrl1;
  logic                           wr_ctrl2;
  logic                           rd_result;
  logic                           rd_irq_stat;
  logic                           wr_irq_mask;

  function automatic logic hit(input logic strobe, input logic [2:0] addr,
                               input logic [2:0] target);
    hit = strobe && (addr == target);
  endfunction : hit

  assign low_power   = stop_slow_mode || sleep_mode;
  assign wr_ctrl1    = hit(reg_wr, reg_addr, `ACS_ADDR_CTRL1);
  assign wr_ctrl2    = hit(reg_wr, reg_addr, `ACS_ADDR_CTRL2);
  assign rd_result   = hit(reg_rd, reg_addr, `ACS_ADDR_RESULT);
  assign rd_irq_stat = hit(reg_rd, reg_addr, `ACS_ADDR_IRQ_STAT);
  assign wr_irq_mask = hit(reg_wr, reg_addr, `ACS_ADDR_IRQ_MASK);

  assign conv.start     = s.ctrl1[`ACS_CR1_START];
  assign conv.abort     = stop_slow_mode;
  assign conv.time_code = acs_pkg::acs_time_e'(s.ctrl2[`ACS_CR2_TIME_HI:`ACS_CR2_TIME_LO]);

  // A start while busy is dropped: the timer only listens when idle
  assign start_take = conv.start && !conv.busy && !stop_slow_mode;

  acs_timer u_timer (
    .clock  (clock),
    .arst_n (arst_n),
    .conv   (conv.timer)
  );

  assign ev_set[`ACS_EV_DONE]  = conv.done && !stop_slow_mode;
  assign ev_set[`ACS_EV_ABORT] = conv.busy && stop_slow_mode;

  acs_irq_unit u_irq (
    .clock      (clock),
    .arst_n     (arst_n),
    .event_set  (ev_set),
    .status_rd  (rd_irq_stat),
    .mask_wr    (wr_irq_mask),
    .mask_wdata (reg_wdata[`ACS_NUM_EV-1:0]),
    .status     (ev_status),
    .mask       (ev_mask),
    .irq        (irq)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s          = s;
    next_s.done_irq = conv.done;

    if (s.ctrl1[`ACS_CR1_START]) begin
      next_s.ctrl1[`ACS_CR1_START] = 1'b0;
    end

    if (start_take) begin
      next_s.end_flag = 1'b0;
    end

    if (rd_result) begin
      next_s.end_flag = 1'b0;
    end

    if (conv.done) begin
      next_s.result   = conv_code;
      next_s.end_flag = 1'b1;
    end

    if (wr_ctrl1) begin
      next_s.ctrl1 = reg_wdata;
    end
    if (wr_ctrl2) begin
      next_s.ctrl2 = reg_wdata;
    end

    if (low_power) begin
      next_s.ctrl1 = `ACS_CR1_RST;
      next_s.ctrl2 = `ACS_CR2_RST;
    end

    if (stop_slow_mode) begin
      next_s.result   = `ACS_RESULT_RST;
      next_s.end_flag = 1'b0;
      next_s.done_irq = 1'b0;
    end

    // Read data live for exactly one cycle after the strobe
    next_s.rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        `ACS_ADDR_CTRL1:    next_s.rdata = s.ctrl1;
        `ACS_ADDR_CTRL2:    next_s.rdata = s.ctrl2;
        `ACS_ADDR_RESULT:   next_s.rdata = s.result;
        `ACS_ADDR_STATUS: begin
          next_s.rdata[`ACS_ST_END]  = s.end_flag;
          next_s.rdata[`ACS_ST_BUSY] = conv.busy;
        end
        `ACS_ADDR_IRQ_STAT: next_s.rdata = {6'h00, ev_status};
        `ACS_ADDR_IRQ_MASK: next_s.rdata = {6'h00, ev_mask};
        default:            next_s.rdata = 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s <= '{ctrl1: `ACS_CR1_RST, ctrl2: `ACS_CR2_RST, result: `ACS_RESULT_RST,
             end_flag: 1'b0, done_irq: 1'b0, rdata: 8'h00};
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata            = s.rdata;
  assign channel_select       = s.ctrl1[`ACS_CR1_CHAN_HI:`ACS_CR1_CHAN_LO];
  assign analog_input_disable = s.ctrl1[`ACS_CR1_AIN_DIS];
  assign ref_current_on       = s.ctrl2[`ACS_CR2_REF_ON];
  assign sample_active        = conv.busy;
  assign conv_done_irq        = s.done_irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!arst_n);

  AST_START_LAUNCH: assert property (
    start_take |=> sample_active)
    else $error("start bit did not launch a conversion");

  AST_START_SELF_CLEAR: assert property (
    (conv.start && !wr_ctrl1) |=> !s.ctrl1[`ACS_CR1_START])
    else $error("start bit did not clear itself");

  AST_DONE_TOGETHER: assert property (
    (conv.done && !stop_slow_mode)
      |=> s.end_flag && conv_done_irq && s.result == $past(conv_code))
    else $error("result, flag and request not delivered together");

  AST_DONE_PULSE: assert property (
    conv_done_irq |=> !conv_done_irq)
    else $error("done request longer than one cycle");

  AST_READ_CLEARS_END: assert property (
    (rd_result && !conv.done) |=> !s.end_flag)
    else $error("reading the result left the end flag set");

  AST_RESTART_KEEPS: assert property (
    (start_take && !conv.done) |=> !s.end_flag && s.result == $past(s.result))
    else $error("restart lost the old result or kept the flag");

  AST_ABORT_RESET: assert property (
    stop_slow_mode |=> !sample_active && s.ctrl1 == `ACS_CR1_RST
                       && s.ctrl2 == `ACS_CR2_RST)
    else $error("stop or slow did not abort and reset controls");

  AST_DISCARD: assert property (
    stop_slow_mode |=> s.result == `ACS_RESULT_RST && !s.end_flag)
    else $error("held result survived stop or slow");

  AST_NO_RESUME: assert property (
    (!sample_active && !conv.start) |=> !sample_active)
    else $error("conversion began without the start bit");

  AST_REF_OFF: assert property (
    stop_slow_mode |=> !ref_current_on)
    else $error("reference still connected in stop or slow");

  AST_BUSY_READ: assert property (
    hit(reg_rd, reg_addr, `ACS_ADDR_STATUS)
      |=> reg_rdata[`ACS_ST_BUSY] == $past(sample_active))
    else $error("busy flag readback wrong");

  AST_SLEEP_IGNORE: assert property (
    (sleep_mode && reg_wr) |=> s.ctrl1 == `ACS_CR1_RST && s.ctrl2 == `ACS_CR2_RST)
    else $error("control written during low power");

  AST_END_FROM_DONE: assert property (
    (!s.end_flag && !conv.done) |=> !s.end_flag)
    else $error("end flag set without a completed conversion");

  AST_DONE_ONLY_ON_END: assert property (
    !conv.done |=> !conv_done_irq)
    else $error("done request without a completed conversion");

  AST_END_HOLDS: assert property (
    (s.end_flag && !rd_result && !start_take && !stop_slow_mode) |=> s.end_flag)
    else $error("end flag dropped without a result read");

  AST_RESULT_HOLDS: assert property (
    (!conv.done && !stop_slow_mode) |=> s.result == $past(s.result))
    else $error("result changed without a completed conversion");

  AST_IRQ_LEVEL: assert property (
    irq == |(ev_status & ev_mask))
    else $error("interrupt level does not follow masked status");

  AST_LOW_POWER_REF: assert property (
    low_power |=> !ref_current_on)
    else $error("reference connected during low power");

  AST_BUSY_CLEARED: assert property (
    (hit(reg_rd, reg_addr, `ACS_ADDR_STATUS) && $past(stop_slow_mode))
      |=> !reg_rdata[`ACS_ST_BUSY])
    else $error("busy flag still set after stop or slow");

  // A whole conversion ends: busy falls, then the done request follows
  COV_FULL_CONV: cover property (sample_active ##1 !sample_active ##1 conv_done_irq);
  COV_RESTART_UNREAD: cover property (s.end_flag && start_take);
  COV_ABORT: cover property (sample_active && stop_slow_mode);
  COV_READ_CLEAR: cover property (s.end_flag && rd_result);

endmodule : acs_top

// ### verif/test_adc_conversion_sequencer.sv
`timescale 1ns/10ps
`include "acs_params.svh"

module test_adc_conversion_sequencer;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clock;
  logic        arst_n;
  logic [2:0]  reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_rdata;
  logic        stop_slow_mode;
  logic        sleep_mode;
  logic [7:0]  conv_code;
  logic [3:0]  channel_select;
  logic        analog_input_disable;
  logic        ref_current_on;
  logic        sample_active;
  logic        conv_done_irq;
  logic        irq;
  int          err_count   = 0;
  int          check_count = 0;
  logic [7:0]  rd_exp[$];
  int          len_exp[$];
  bit          done_exp[$];
  logic        rd_q        = 1'b0;
  logic        done_prev   = 1'b0;
  int          run_len     = 0;
  int          done_cnt    = 0;
  logic [31:0] rnd         = 32'h33b868d8;
  logic [7:0]  last_code   = 8'h00;
  logic [2:0]  tcode [6]   = '{3'b000, 3'b010, 3'b011, 3'b100, 3'b101, 3'b110};
  logic [10:0] tlen  [6]   = '{`ACS_CYC_39, `ACS_CYC_78, `ACS_CYC_156,
                               `ACS_CYC_312, `ACS_CYC_624, `ACS_CYC_1248};

  acs_top i_dut (
    .clock                (clock),
    .arst_n               (arst_n),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .stop_slow_mode       (stop_slow_mode),
    .sleep_mode           (sleep_mode),
    .conv_code            (conv_code),
    .channel_select       (channel_select),
    .analog_input_disable (analog_input_disable),
    .ref_current_on       (ref_current_on),
    .sample_active        (sample_active),
    .conv_done_irq        (conv_done_irq),
    .irq                  (irq)
  );

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  task automatic fail(input string msg);
    err_count++;
    $display("CHECK FAILED at %0t: %s", $time, msg);
  endtask : fail

  task automatic cmp_rd(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) fail($sformatf("read data %h, expected %h", got, exp));
  endtask : cmp_rd

  task automatic cmp_len(input int got, input int exp);
    // Zero marks an aborted run whose length is not predicted
    if (exp != 0) begin
      check_count++;
      if (got != exp) fail($sformatf("busy for %0d cycles, expected %0d", got, exp));
    end
  endtask : cmp_len

  task automatic cmp_pin(input logic got, input logic exp, input string what);
    check_count++;
    if (got !== exp) fail($sformatf("%s is %b, expected %b", what, got, exp));
  endtask : cmp_pin

  task automatic wr(input logic [2:0] addr, input logic [7:0] data);
    @(posedge clock);
    reg_addr  <= addr;
    reg_wdata <= data;
    reg_wr    <= 1'b1;
    @(posedge clock);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [2:0] addr, input logic [7:0] exp);
    @(posedge clock);
    reg_addr <= addr;
    reg_rd   <= 1'b1;
    rd_exp.push_back(exp);
    @(posedge clock);
    reg_rd   <= 1'b0;
  endtask : rd

  task automatic wait_busy();
    for (int k = 0; k < 8 && sample_active !== 1'b1; k++) @(negedge clock);
  endtask : wait_busy

  task automatic conclude();
    $display("Comparisons %0d, mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude

  // Odd runs restart with the previous result still unread
  task automatic run_conv(input int i);
    logic [3:0] chan;
    logic [7:0] code;
    int         old;
    rnd  = xs(rnd);
    chan = 4'(rnd[15:0] % 6);
    code = rnd[31:24];
    conv_code <= code;
    wr(`ACS_ADDR_CTRL2, {3'b001, 1'b1, tcode[i], 1'b0});
    len_exp.push_back(int'(tlen[i]));
    done_exp.push_back(1'b1);
    wr(`ACS_ADDR_CTRL1, {4'h0, chan});
    wr(`ACS_ADDR_CTRL1, {4'h8, chan});
    wait_busy();
    cmp_pin(channel_select == chan && !analog_input_disable, 1'b1, "channel");
    // only this block's registers are touched while converting
    rd(`ACS_ADDR_CTRL1, {4'h0, chan});
    rd(`ACS_ADDR_STATUS, 8'h10);
    rd(`ACS_ADDR_RESULT, last_code);
    // no restart before completion is seen
    old = done_cnt;
    for (int k = 0; k < 1400 && done_cnt == old; k++) @(posedge clock);
    @(negedge clock);
    cmp_pin(done_cnt == old + 1, 1'b1, "completion");
    cmp_pin(irq, i >= 3, "irq level");
    last_code = code;
    rd(`ACS_ADDR_STATUS, 8'h20);
    rd(`ACS_ADDR_IRQ_STAT, 8'h01);
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp_pin(irq, 1'b0, "irq after clear");
    if (i[0]) begin
      rd(`ACS_ADDR_RESULT, last_code);
      rd(`ACS_ADDR_STATUS, 8'h00);
    end
  endtask : run_conv

  // ---------------------------------------------------------------
  // Clock, monitor and watchdog
  // ---------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  always @(posedge clock) rd_q <= reg_rd;

  always @(negedge clock) begin
    if (rd_q) cmp_rd(reg_rdata, rd_exp.pop_front());
    if (conv_done_irq === 1'b1) begin
      done_cnt++;
      cmp_pin(done_exp.size() != 0 && !done_prev, 1'b1, "done pulse");
      if (done_exp.size() != 0) void'(done_exp.pop_front());
    end
    done_prev = (conv_done_irq === 1'b1);
    if (sample_active === 1'b1) run_len++;
    else if (run_len != 0) begin
      cmp_len(run_len, len_exp.size() != 0 ? len_exp.pop_front() : -1);
      run_len = 0;
    end
  end

  // Whole run needs roughly 4100 cycles
  initial begin
    repeat (12000) @(posedge clock);
    fail("watchdog expired");
    conclude();
  end

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n         = 1'b0;
    reg_addr       = 3'h0;
    reg_wdata      = 8'h00;
    reg_wr         = 1'b0;
    reg_rd         = 1'b0;
    stop_slow_mode = 1'b0;
    sleep_mode     = 1'b0;
    conv_code      = 8'h00;
    repeat (12) @(posedge clock);
    arst_n <= 1'b1;
    wr(3'h6, 8'hff);
    for (int a = 0; a < 8; a++) rd(3'(a), a == 0 ? `ACS_CR1_RST : 8'h00);
    for (int i = 0; i < 6; i++) begin
      if (i == 3) begin
        wr(`ACS_ADDR_IRQ_MASK, 8'h03);
        rd(`ACS_ADDR_IRQ_MASK, 8'h03);
      end
      run_conv(i);
    end
    // Abort a long conversion by low-power entry
    len_exp.push_back(0);
    wr(`ACS_ADDR_CTRL2, 8'h3c);
    wr(`ACS_ADDR_CTRL1, 8'h02);
    wr(`ACS_ADDR_CTRL1, 8'h82);
    wait_busy();
    repeat (50) @(posedge clock);
    cmp_pin(ref_current_on, 1'b1, "ref before stop");
    stop_slow_mode <= 1'b1;
    repeat (2) @(posedge clock);
    @(negedge clock);
    cmp_pin(sample_active, 1'b0, "busy after stop");
    cmp_pin(ref_current_on, 1'b0, "ref after stop");
    cmp_pin(analog_input_disable && channel_select == 4'h0, 1'b1, "ctrl1 pins");
    wr(`ACS_ADDR_CTRL1, 8'h85);
    cmp_pin(irq, 1'b1, "abort irq");
    rd(`ACS_ADDR_CTRL1, `ACS_CR1_RST);
    rd(`ACS_ADDR_CTRL2, `ACS_CR2_RST);
    rd(`ACS_ADDR_RESULT, 8'h00);
    rd(`ACS_ADDR_STATUS, 8'h00);
    rd(`ACS_ADDR_IRQ_STAT, 8'h02);
    stop_slow_mode <= 1'b0;
    // A resumed run would show up in the monitor as an unexpected pulse
    repeat (1400) @(posedge clock);
    cmp_pin(sample_active, 1'b0, "no resume");
    // Writes are dropped while sleeping, taken again afterwards
    sleep_mode <= 1'b1;
    wr(`ACS_ADDR_CTRL2, 8'h3c);
    rd(`ACS_ADDR_CTRL2, 8'h00);
    sleep_mode <= 1'b0;
    wr(`ACS_ADDR_CTRL2, 8'h3c);
    rd(`ACS_ADDR_CTRL2, 8'h3c);
    repeat (3) @(posedge clock);
    conclude();
  end
endmodule : test_adc_conversion_sequencer
